// ### src/panel_out_cfg.svh
// Constants of the synchronous panel output stage: offsets, fields, resets, timing.
// Assumes inclusion by bare name from files that need the numbers.
`ifndef PANEL_OUT_CFG_SVH
`define PANEL_OUT_CFG_SVH

// Register word indices on the plain register port
`define CFG_ADDR 4'h0
`define HRES_ADDR 4'h1
`define RST_ADDR 4'h2
`define STAT_ADDR 4'h3

// Field positions of panel_config_register
`define CFG_POL_BIT 0
`define CFG_LAUNCH_BIT 1
`define CFG_ASYNC_BIT 2
`define CFG_SYNC_EN_BIT 3
`define CFG_DIV_LSB 8
`define CFG_DIV_MSB 15

// Field positions of the reset, status and horizontal resolution words
`define RST_LEVEL_BIT 0
`define RST_PULSE_BIT 1
`define STAT_SHORT_BIT 0
`define STAT_PCLK_BIT 1
`define STAT_RST_BIT 2
`define STAT_EMPTY_BIT 3
`define HRES_MSB 11

// Reset values and limits
`define DIV_RESET 8'h04
`define DIV_MIN 8'h03
`define HRES_RESET 12'h320
`define HRES_SVGA 12'h320
`define HRES_MIN 12'h001
`define RGB_MAX 24

// Timing: pixel clock ceiling and panel reset width
`define CLK_PERIOD_NS 100
`define CLK_KHZ 10000
`define PCLK_MAX_KHZ 44400
`define RST_WIDTH_NS 15
`define RST_PULSE_RAW ((`RST_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_CYCLES ((`RST_PULSE_RAW < 1) ? 1 : `RST_PULSE_RAW)

`endif

// ### src/panel_out_pkg.sv
// Types shared by the panel output stage.
// Assumes the cfg header supplies all numeric constants.
package panel_out_pkg;

	// Panel reset pulse sequencer
	typedef enum logic [1:0] {
		RST_IDLE = 2'b01,
		RST_PULSE = 2'b10
	} rst_state_e;

	// Per-pixel side-band flags carried beside the colour bits
	typedef struct packed {
		logic vsync;
		logic hsync;
		logic de;
	} pix_flags_s;

endpackage : panel_out_pkg

// ### src/pix_stream_if.sv
// Valid/ready carrier for pixel words between buffer and output stage.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface pix_stream_if #(parameter int W = 27);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : pix_stream_if

// ### src/pix_skid_buffer.sv
// Two-entry pixel buffer, valid/ready on both sides.
// Assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ps
module pix_skid_buffer #(
	parameter int W = 27,
	parameter int DEPTH = 2
) (
	// Clock and control
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Filling side
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [W-1:0] s_data,
	// Draining side
	pix_stream_if.source m
);
	if (DEPTH != 2) begin : g_bad_depth
		$error("pix_skid_buffer serves a depth of two only");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic ready;
		logic valid;
	} buf_s;

	buf_s st_reg;
	buf_s st_next;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////
	// Next state; ready and valid are registered so ports come from flops
	always_comb begin
		st_next = st_reg;
		push = s_valid && st_reg.ready;
		pop = st_reg.valid && m.ready;
		if (push) begin
			st_next.mem[st_reg.wp] = s_data;
			st_next.wp = ~st_reg.wp;
		end
		if (pop) begin
			st_next.rp = ~st_reg.rp;
		end
		st_next.cnt = st_reg.cnt + 2'(push) - 2'(pop);
		st_next.ready = (st_next.cnt != 2'h2);
		st_next.valid = (st_next.cnt != 2'h0);
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.ready <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign s_ready = st_reg.ready;
	assign m.valid = st_reg.valid;
	assign m.data = st_reg.mem[st_reg.rp];

	// A full buffer with no drain keeps its head word and takes nothing
	chk_full_refuses: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && st_reg.cnt == 2'h2 && !m.ready) |=> (st_reg.cnt == 2'h2 && $stable(m.data)))
		else $error("buffer lost a word while full");

endmodule : pix_skid_buffer

// ### src/sync_panel_pixel_output.sv
// Output stage of a synchronous RGB panel port: launch edge, polarity, syncs, reset.
// Assumes pixel words arrive already timed, one word per pixel clock slot.
//
// Notes on behaviour
// - Rising-edge launch for falling-edge sampling panel
// - Active-high polarity passes colour bits unchanged
// - Active-low polarity inverts every RGB bit
// - Polarity chosen by software config register field
// - Panel reset held low at least 15 ns
// - Synchronous or asynchronous panel, never both
// - Up to 24-bit RGB, up to SVGA width
// - Data enable, pixel clock, optional line/frame syncs
// - Pixel clock stays below 44.4 MHz
// - Data enable lasts at most horizontal resolution per line
// - Pixel clock period at least three clocks
`timescale 1ns/1ps
`include "panel_out_cfg.svh"
module sync_panel_pixel_output #(
	parameter int RGB_W = 24
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	// Pixel stream in
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic [RGB_W-1:0] pix_rgb,
	input wire logic pix_de,
	input wire logic pix_hsync,
	input wire logic pix_vsync,
	// Panel pins
	output logic panel_pixel_clock,
	output logic [RGB_W-1:0] panel_rgb,
	output logic panel_de,
	output logic panel_hsync_n,
	output logic panel_vsync_n,
	output logic panel_reset_n,
	output logic async_panel_select
);
	localparam int W = RGB_W + 3;
	localparam logic [3:0] RST_CYC = 4'(`RST_PULSE_CYCLES);

	if (RGB_W < 1 || RGB_W > `RGB_MAX) begin : g_bad_width
		$error("RGB width must be 1 to 24 bits");
	end
	if (`CLK_KHZ / `DIV_MIN >= `PCLK_MAX_KHZ) begin : g_bad_clock
		$error("system clock too fast for pixel clock ceiling");
	end
	if (`RST_PULSE_CYCLES > 15) begin : g_bad_rst
		$error("panel reset count exceeds its counter");
	end

	typedef struct packed {
		logic [31:0] rdata;
		logic pol;
		logic launch_rise;
		logic async_sel;
		logic sync_en;
		logic [7:0] div;
		logic [7:0] div_run;
		logic [11:0] hres;
		logic rst_level;
		panel_out_pkg::rst_state_e rst_state;
		logic [3:0] rst_cnt;
		logic panel_rst_n;
		logic line_short;
		logic [7:0] cnt;
		logic pclk;
		logic [RGB_W-1:0] rgb;
		logic de;
		logic hsync_n;
		logic vsync_n;
		logic [11:0] de_cnt;
	} out_s;

	out_s st_reg;
	out_s st_next;
	pix_stream_if #(.W(W)) bus ();

	panel_out_pkg::pix_flags_s fl;
	logic [RGB_W-1:0] in_rgb;
	logic [7:0] div_eff;
	logic [7:0] half;
	logic [7:0] cnt_nx;
	logic pclk_nx;
	logic launch;
	logic take;
	logic [11:0] hres_w;

	// Address decode used by the write paths; reads decode with a case
	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
		return a == idx;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// Input buffer; a stalled panel slot leaves words waiting here
	pix_skid_buffer #(
		.W(W),
		.DEPTH(2)
	) u_buf (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.s_valid(pix_valid),
		.s_ready(pix_ready),
		.s_data({pix_vsync, pix_hsync, pix_de, pix_rgb}),
		.m(bus.source)
	);

	assign fl = bus.data[W-1:RGB_W];
	assign in_rgb = bus.data[RGB_W-1:0];
	// Buffer drains only on a launch slot in synchronous mode
	assign bus.ready = launch;

	////////////////////////////////////////////////////////////////////////
	// Divider clamped to three system clocks at least
	assign div_eff = (st_reg.div_run < `DIV_MIN) ? `DIV_MIN : st_reg.div_run;
	assign half = div_eff >> 1;
	assign cnt_nx = (st_reg.cnt >= div_eff - 8'h01) ? 8'h00 : st_reg.cnt + 8'h01;
	assign pclk_nx = !st_reg.async_sel && (cnt_nx < half);
	assign launch = !st_reg.async_sel &&
		(st_reg.launch_rise ? (pclk_nx && !st_reg.pclk) : (!pclk_nx && st_reg.pclk));
	assign take = launch && bus.valid;
	assign hres_w = reg_wdata[`HRES_MSB:0];

	////////////////////////////////////////////////////////////////////////
	// Next state of registers, divider, reset sequencer and pins
	always_comb begin
		st_next = st_reg;
		st_next.rdata = '0;
		// Register writes
		if (reg_we && hit(reg_addr, `CFG_ADDR)) begin
			st_next.pol = reg_wdata[`CFG_POL_BIT];
			st_next.launch_rise = reg_wdata[`CFG_LAUNCH_BIT];
			st_next.async_sel = reg_wdata[`CFG_ASYNC_BIT];
			st_next.sync_en = reg_wdata[`CFG_SYNC_EN_BIT];
			st_next.div = reg_wdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
		end
		if (reg_we && hit(reg_addr, `HRES_ADDR)) begin
			if (hres_w > `HRES_SVGA) begin
				st_next.hres = `HRES_SVGA;
			end else if (hres_w < `HRES_MIN) begin
				st_next.hres = `HRES_MIN;
			end else begin
				st_next.hres = hres_w;
			end
		end
		if (reg_we && hit(reg_addr, `STAT_ADDR) && reg_wdata[`STAT_SHORT_BIT]) begin
			st_next.line_short = 1'b0;
		end
		// Register reads, data in the following cycle only
		if (reg_re) begin
			unique case (reg_addr)
				`CFG_ADDR: begin
					st_next.rdata[`CFG_POL_BIT] = st_reg.pol;
					st_next.rdata[`CFG_LAUNCH_BIT] = st_reg.launch_rise;
					st_next.rdata[`CFG_ASYNC_BIT] = st_reg.async_sel;
					st_next.rdata[`CFG_SYNC_EN_BIT] = st_reg.sync_en;
					st_next.rdata[`CFG_DIV_MSB:`CFG_DIV_LSB] = st_reg.div;
				end
				`HRES_ADDR: begin
					st_next.rdata[`HRES_MSB:0] = st_reg.hres;
				end
				`RST_ADDR: begin
					st_next.rdata[`RST_LEVEL_BIT] = st_reg.rst_level;
				end
				`STAT_ADDR: begin
					st_next.rdata[`STAT_SHORT_BIT] = st_reg.line_short;
					st_next.rdata[`STAT_PCLK_BIT] = st_reg.pclk;
					st_next.rdata[`STAT_RST_BIT] = !st_reg.panel_rst_n;
					st_next.rdata[`STAT_EMPTY_BIT] = !bus.valid;
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end

		// Software reset line and timed low pulse
		if (reg_we && hit(reg_addr, `RST_ADDR)) begin
			st_next.rst_level = reg_wdata[`RST_LEVEL_BIT];
		end
		unique case (st_reg.rst_state)
			panel_out_pkg::RST_IDLE: begin
				if (reg_we && hit(reg_addr, `RST_ADDR) && reg_wdata[`RST_PULSE_BIT]) begin
					st_next.rst_state = panel_out_pkg::RST_PULSE;
					st_next.rst_cnt = RST_CYC;
				end
			end
			panel_out_pkg::RST_PULSE: begin
				st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
				if (st_reg.rst_cnt == 4'h1) begin
					st_next.rst_state = panel_out_pkg::RST_IDLE;
				end
			end
			default: begin
				st_next.rst_state = panel_out_pkg::RST_IDLE;
			end
		endcase
		st_next.panel_rst_n = !(st_next.rst_level ||
			(st_next.rst_state == panel_out_pkg::RST_PULSE));

		// Asynchronous panel parks every synchronous pin
		if (st_reg.async_sel) begin
			st_next.cnt = '0;
			st_next.div_run = st_reg.div;
			st_next.pclk = 1'b0;
			st_next.de = 1'b0;
			st_next.rgb = '0;
			st_next.hsync_n = 1'b1;
			st_next.vsync_n = 1'b1;
			st_next.de_cnt = '0;
		end else begin
			st_next.cnt = cnt_nx;
			st_next.pclk = pclk_nx;
			// New divider only at a period boundary, so no short pulse
			if (cnt_nx == 8'h00) begin
				st_next.div_run = st_reg.div;
			end
		end

		// With a synchronous panel, data and sync pins change only in a launch slot
		if (launch) begin
			if (take) begin
				st_next.rgb = st_reg.pol ? ~in_rgb : in_rgb;
				st_next.de = fl.de && (st_reg.de_cnt < st_reg.hres);
				if (fl.de && (st_reg.de_cnt < st_reg.hres)) begin
					st_next.de_cnt = st_reg.de_cnt + 12'h001;
				end
				// Syncs only when enabled, active low
				st_next.hsync_n = !(fl.hsync && st_reg.sync_en);
				st_next.vsync_n = !(fl.vsync && st_reg.sync_en);
				if (fl.hsync) begin
					st_next.de_cnt = '0;
					// Set wins over a same-cycle software clear
					if (st_reg.de_cnt != 12'h000 && st_reg.de_cnt != st_reg.hres) begin
						st_next.line_short = 1'b1;
					end
				end
			end else begin
				// Underrun: idle pixel, blank slot rather than stale data
				st_next.rgb = st_reg.pol ? '1 : '0;
				st_next.de = 1'b0;
				st_next.hsync_n = 1'b1;
				st_next.vsync_n = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; ce low freezes everything including the divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.div <= `DIV_RESET;
			st_reg.div_run <= `DIV_RESET;
			st_reg.hres <= `HRES_RESET;
			st_reg.rst_state <= panel_out_pkg::RST_IDLE;
			st_reg.panel_rst_n <= 1'b1;
			st_reg.hsync_n <= 1'b1;
			st_reg.vsync_n <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// Pins straight from the state register
	assign reg_rdata = st_reg.rdata;
	assign panel_pixel_clock = st_reg.pclk;
	assign panel_rgb = st_reg.rgb;
	assign panel_de = st_reg.de;
	assign panel_hsync_n = st_reg.hsync_n;
	assign panel_vsync_n = st_reg.vsync_n;
	assign panel_reset_n = st_reg.panel_rst_n;
	assign async_panel_select = st_reg.async_sel;

	////////////////////////////////////////////////////////////////////////
	// Checks beside the logic
	chk_rise_launch_data: assert property (@(posedge clk) disable iff (!arst_n)
		($changed(st_reg.rgb) && $past(st_reg.launch_rise) && !st_reg.async_sel)
		|-> st_reg.pclk)
		else $error("rising launch changed data away from rising edge");

	chk_pol_high_pass: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && take && !st_reg.pol) |=> (st_reg.rgb == $past(in_rgb)))
		else $error("active-high pixel not passed unchanged");

	chk_pol_low_invert: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && take && st_reg.pol) |=> (st_reg.rgb == ~$past(in_rgb)))
		else $error("active-low pixel not inverted");

	chk_pol_field_write: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && reg_we && reg_addr == `CFG_ADDR)
		|=> (st_reg.pol == $past(reg_wdata[`CFG_POL_BIT])))
		else $error("polarity field not taken from write");

	chk_reset_pulse_low: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && reg_we && reg_addr == `RST_ADDR && reg_wdata[`RST_PULSE_BIT]
		&& st_reg.rst_state == panel_out_pkg::RST_IDLE)
		|=> !panel_reset_n)
		else $error("panel reset pulse missing");

	chk_async_parks_sync: assert property (@(posedge clk) disable iff (!arst_n)
		($past(st_reg.async_sel) && st_reg.async_sel)
		|-> (!panel_pixel_clock && !panel_de && async_panel_select))
		else $error("synchronous pins active with asynchronous panel");

	chk_hres_svga_cap: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg.hres <= `HRES_SVGA && st_reg.hres >= `HRES_MIN)
		else $error("horizontal resolution beyond SVGA");

	chk_sync_disabled_idle: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && launch && !st_reg.sync_en) |=> (panel_hsync_n && panel_vsync_n))
		else $error("sync pulse while syncs disabled");

	chk_pclk_third_rate: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(st_reg.pclk) |=> !$rose(st_reg.pclk) ##1 !$rose(st_reg.pclk))
		else $error("pixel clock faster than a third of system clock");

	chk_de_count_cap: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg.de |-> (st_reg.de_cnt <= st_reg.hres && st_reg.de_cnt != 12'h000))
		else $error("data enable beyond horizontal resolution");

	chk_pins_on_edge: assert property (@(posedge clk) disable iff (!arst_n)
		($changed(st_reg.de) || $changed(st_reg.hsync_n)) && !st_reg.async_sel
		&& !$past(st_reg.async_sel) |-> $changed(st_reg.pclk))
		else $error("pins changed away from a pixel clock edge");

endmodule : sync_panel_pixel_output

// ### sim/sync_panel_model.sv
// Panel model: latches pins on its own sampling edge of the pixel clock.
// Assumes pins are registered on clk; it looks one clk after each pixel clock edge.
`timescale 1ns/1ps
module sync_panel_model (
	// Clock and control
	input wire logic clk,
	input wire logic clr,
	input wire logic sample_fall,
	// Panel pins
	input wire logic pclk,
	input wire logic [15:0] rgb,
	input wire logic de,
	input wire logic hsync_n,
	// Observations
	output logic [15:0] last_rgb,
	output logic [15:0] de_cnt,
	output logic [15:0] hs_cnt,
	output logic [15:0] bad_edge
);
	logic pclk_d;
	logic [15:0] rgb_d;
	logic smp;

	////////////////////////////////////////
	// Sampling edge seen a clk late, so the pins have settled
	assign smp = (pclk != pclk_d) && (pclk == !sample_fall);

	always @(posedge clk) begin
		pclk_d <= pclk;
		rgb_d <= rgb;
		if (clr) begin
			de_cnt <= 16'h0000;
			hs_cnt <= 16'h0000;
			bad_edge <= 16'h0000;
		end else if (smp) begin
			// Pins moving at the latch edge would be a race on the panel
			if (rgb !== rgb_d) bad_edge <= bad_edge + 16'h0001;
			if (hsync_n === 1'b0) hs_cnt <= hs_cnt + 16'h0001;
			if (de === 1'b1) begin
				de_cnt <= de_cnt + 16'h0001;
				last_rgb <= rgb;
			end
		end
	end
endmodule : sync_panel_model

// ### sim/sync_panel_pixel_output_tb_top.sv
// Bench of the panel output stage: register tasks, pixel pushes, pin checks.
// Assumes a 16-bit colour bus and the panel model on the pins.
`timescale 1ns/1ps
`include "panel_out_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module sync_panel_pixel_output_tb_top;
	logic clk, arst_n, ce, reg_we, reg_re, pix_valid, pix_ready, pix_de, pix_hsync, pix_vsync;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] pix_rgb, panel_rgb, last_rgb, de_cnt, hs_cnt, bad_edge;
	logic pclk, panel_de, hs_n, vs_n, rst_n, async_sel, clr, sample_fall, pclk_q, rdy_q, saw_full;
	logic [31:0] hw [3] = '{32'h0000_0000, 32'h0000_0FFF, 32'h0000_0004};
	logic [31:0] he [3] = '{32'h0000_0001, 32'h0000_0320, 32'h0000_0004};
	int err_count, n_compared, i, hi, lo, pe, rst_low, vs_low;

	sync_panel_pixel_output #(.RGB_W(16)) uut (.clk(clk), .arst_n(arst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_rgb(pix_rgb),
		.pix_de(pix_de), .pix_hsync(pix_hsync), .pix_vsync(pix_vsync),
		.panel_pixel_clock(pclk), .panel_rgb(panel_rgb), .panel_de(panel_de),
		.panel_hsync_n(hs_n), .panel_vsync_n(vs_n), .panel_reset_n(rst_n),
		.async_panel_select(async_sel));
	sync_panel_model pm (.clk(clk), .clr(clr), .sample_fall(sample_fall), .pclk(pclk),
		.rgb(panel_rgb), .de(panel_de), .hsync_n(hs_n), .last_rgb(last_rgb),
		.de_cnt(de_cnt), .hs_cnt(hs_cnt), .bad_edge(bad_edge));

	////////////////////////////////////////
	// Clock, and settled copies of outputs taken mid-cycle
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(negedge clk) begin
		pclk_q <= pclk;
		rdy_q <= pix_ready;
		if (clr) begin
			saw_full <= 1'b0;
			rst_low <= 0;
			vs_low <= 0;
		end else begin
			if (pix_ready === 1'b0) saw_full <= 1'b1;
			if (rst_n === 1'b0) rst_low <= rst_low + 1;
			if (vs_n === 1'b0) vs_low <= vs_low + 1;
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		v = reg_rdata;
		@(posedge clk);
	endtask : rd

	// Word held until the edge that finds ready high
	task automatic push(input logic [2:0] f, input logic [15:0] c);
		int k = 0;
		{pix_vsync, pix_hsync, pix_de} <= f;
		pix_rgb <= c;
		pix_valid <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (rdy_q !== 1'b1 && k < 50);
	endtask : push

	task automatic idle(input int n);
		pix_valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic mclr;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask : mclr

	// Bounded waits, so a dead pixel clock shows as a wrong count
	task automatic period(output int h, output int l);
		h = 0;
		l = 0;
		while (pclk_q !== 1'b0 && l < 20) begin @(negedge clk); l++; end
		while (pclk_q !== 1'b1 && l < 40) begin @(negedge clk); l++; end
		l = 0;
		while (pclk_q === 1'b1 && h < 20) begin @(negedge clk); h++; end
		while (pclk_q === 1'b0 && l < 20) begin @(negedge clk); l++; end
	endtask : period

	task test_done;
		$display("compared=%0d errors=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done

	initial begin
		#2_000_000;
		err_count++;
		test_done();
	end

	////////////////////////////////////////
	initial begin
		{arst_n, reg_we, reg_re, pix_valid, pix_de, pix_hsync, pix_vsync, sample_fall} = 8'h00;
		{ce, clr} = 2'b11;
		{reg_addr, reg_wdata, pix_rgb, err_count, n_compared} = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		clr <= 1'b0;
		@(posedge clk);
		`CHK(hs_n, 1'b1)
		rd(`CFG_ADDR, d);
		`CHK(d, 32'h0000_0400)
		wr(4'h9, 32'hFFFF_FFFF);
		rd(4'h9, d);
		`CHK(d, 32'h0000_0000)
		for (i = 0; i < 3; i++) begin
			wr(`HRES_ADDR, hw[i]);
			rd(`HRES_ADDR, d);
			`CHK(d, he[i])
		end
		#1;
		`CHK(reg_rdata, 32'h0000_0000)
		// Divider clamp and duty
		for (i = 2; i < 9; i += 3) begin
			wr(`CFG_ADDR, {16'h0000, i[7:0], 8'h00});
			period(hi, lo);
			pe = (i < 3) ? 3 : i;
			`CHK(hi, pe / 2)
			`CHK(hi + lo, pe)
		end
		// Polarity, launch edge and sync enable combinations
		for (i = 0; i < 4; i++) begin
			wr(`CFG_ADDR, {16'h0000, 8'h04, 4'h0, i[0], 1'b0, i[1], i[0]});
			sample_fall <= i[1];
			idle(8);
			mclr();
			push(3'b110, 16'h0000);
			push(3'b001, 16'hF800);
			idle(24);
			`CHK(last_rgb, i[0] ? 16'h07FF : 16'hF800)
			`CHK(de_cnt, 16'h0001)
			`CHK(hs_cnt, {15'h0000, i[0]})
			`CHK(vs_low, i[0] ? 4 : 0)
			`CHK(bad_edge, 16'h0000)
		end
		// Line of six words against a width of four
		wr(`CFG_ADDR, 32'h0000_0400);
		sample_fall <= 1'b0;
		idle(8);
		mclr();
		push(3'b010, 16'h0000);
		repeat (6) push(3'b001, 16'h1234);
		idle(40);
		`CHK(de_cnt, 16'h0004)
		wr(`STAT_ADDR, 32'h0000_0001);
		push(3'b010, 16'h0000);
		repeat (2) push(3'b001, 16'h0F0F);
		push(3'b010, 16'h0000);
		idle(30);
		rd(`STAT_ADDR, d);
		`CHK(d[0], 1'b1)
		wr(`STAT_ADDR, 32'h0000_0001);
		repeat (4) push(3'b001, 16'h00F0);
		push(3'b010, 16'h0000);
		idle(30);
		rd(`STAT_ADDR, d);
		`CHK(d[0], 1'b0)
		`CHK(d[3], 1'b1)
		// Back-to-back words fill the buffer and none is lost
		wr(`HRES_ADDR, 32'h0000_0320);
		mclr();
		push(3'b010, 16'h0000);
		for (i = 0; i < 10; i++) push(3'b001, i[15:0]);
		idle(60);
		`CHK(de_cnt, 16'h000A)
		`CHK(saw_full, 1'b1)
		// Panel reset pulse, then held level
		mclr();
		wr(`RST_ADDR, 32'h0000_0002);
		idle(6);
		`CHK(rst_low, `RST_PULSE_CYCLES)
		wr(`RST_ADDR, 32'h0000_0001);
		idle(3);
		`CHK(rst_n, 1'b0)
		rd(`STAT_ADDR, d);
		`CHK(d[2], 1'b1)
		wr(`RST_ADDR, 32'h0000_0000);
		idle(3);
		`CHK(rst_n, 1'b1)
		// Clock enable low freezes the pixel clock
		ce <= 1'b0;
		idle(2);
		d = {31'h0000_0000, pclk};
		lo = 0;
		repeat (8) @(negedge clk) if (pclk !== d[0]) lo++;
		@(posedge clk);
		ce <= 1'b1;
		`CHK(lo, 0)
		// Asynchronous panel parks the pixel clock
		wr(`CFG_ADDR, 32'h0000_0404);
		idle(4);
		hi = 0;
		repeat (16) @(negedge clk) if (pclk_q !== 1'b0) hi++;
		`CHK(hi, 0)
		`CHK(async_sel, 1'b1)
		test_done();
	end
endmodule : sync_panel_pixel_output_tb_top
